// ### hw/sla_link_tx.sv
// Contract
// - After sync request releases high, send exactly four alignment multiframes.
// - Pad every alignment multiframe with dummy octets to its full length.
// - First alignment multiframe starts with K28.0, ends with K28.3.
// - Second multiframe: K28.0, K28.4, fourteen config octets, ends K28.3.
// - Third and fourth multiframes repeat the first one exactly.
// - Scrambling off: replace frame-end octet equal to previous frame-end octet.
// - Scrambling on: replace multiframe end 0x7C, other frame end 0xFC.
// - Config octets 0..13 carry ids, link parameters, two spares, checksum.
// - Lane control bit 0 set disables the link and holds it in reset.
// - Sixteen-bit slot: eleven converter bits plus spare bits, tail zeros default.
// - Tail bits zero by default; lane control bit 6 makes them pseudo-random.
// - Control bit count selects control bits over tail; tail config field.
// - Lane, device and bank ids programmable and sent in config octets.
// - Frames per multiframe equals register value plus one, default 32.
// - Scramble enable defaults on; applied only in data transmission phase.
// - Lane control bits 3:2 select alignment once, skipped, or repeated.
// - Report fixed resolution, bits per sample and control words per frame.
// - Derive lanes, octets, density, converters, samples from quick configuration; code derives only octets and converters, the rest are fixed.
// - Checksum is modulo 256 sum of unpacked parameter fields.
// - Checksum sent in second multiframe and readable at 0x79.
// - Send continuous K28.5 while sync request is asserted.
// - Replacement is K28.3 at multiframe end, K28.7 at other frames.
// - Clearing lane control bit 0 releases the lane to synchronise.
`timescale 1ns/1ps
`include "sla_defines.svh"

module sla_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    // Pointers wrap freely, so DEPTH must be a power of two
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic rdy_ff, nxt_rdy;
    logic push, pop;

    always_comb begin
        push = in_valid && rdy_ff;
        pop = out_ready && (cnt_ff != '0);
        nxt_wr = wr_ff + AW'(push);
        nxt_rd = rd_ff + AW'(pop);
        nxt_cnt = cnt_ff + CW'(push) - CW'(pop);
        if (flush) begin
            nxt_wr = '0;
            nxt_rd = '0;
            nxt_cnt = '0;
        end
        // Registered ready: full is known one edge ahead
        nxt_rdy = !flush && (nxt_cnt != CW'(DEPTH));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
            rdy_ff <= 1'b0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
            rdy_ff <= nxt_rdy;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    assign in_ready = rdy_ff;
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem_ff[rd_ff];
endmodule : sla_fifo

module sla_link_tx import sla_pkg::*; #(
    parameter logic [7:0] QUICK_CFG = `SLA_QC_DEFAULT,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic SYNC_N,
    input wire logic [10:0] SMP_DATA,
    input wire logic SMP_OVR,
    input wire logic SMP_VALID,
    output logic SMP_READY,
    output logic [7:0] LANE_OCTET,
    output logic LANE_CTRL,
    output logic LANE_SCRAMBLE,
    output logic LANE_ACTIVE
);
    // Derived link shape, fixed by the quick configuration
    localparam bit DUAL = (QUICK_CFG == `SLA_QC_DUAL);
    localparam logic [7:0] F_M1 = DUAL ? 8'h03 : 8'h01;
    localparam logic [7:0] M_M1 = DUAL ? 8'h01 : 8'h00;
    localparam logic [4:0] L_M1 = 5'h00;
    localparam logic [4:0] S_M1 = 5'h00;
    localparam logic HD = 1'b0;

    logic [7:0] tail_ff, nxt_tail, lane_ff, nxt_lane, did_ff, nxt_did, fpm_ff, nxt_fpm;
    logic [3:0] bid_ff, nxt_bid;
    logic [4:0] lid_ff, nxt_lid;
    logic [1:0] cs_ff, nxt_cs;
    logic scr_ff, nxt_scr;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [7:0] chk;

    sla_state_t st_ff, nxt_st;
    sla_ilas_t mode;
    logic [1:0] oct_ff, nxt_oct, mf_ff, nxt_mf;
    logic [4:0] frm_ff, nxt_frm;
    logic [7:0] prev_ff, nxt_prev, hold_ff, nxt_hold;
    logic prev_ok_ff, nxt_prev_ok;
    logic [14:0] lfsr_ff, nxt_lfsr;
    logic [7:0] oct_out_ff, nxt_oct_out;
    logic ctrl_ff, nxt_ctrl, scro_ff, nxt_scro, act_ff, nxt_act;

    logic lane_rst, prn, at_fe, at_me, pop;
    logic [7:0] idx, cfg_oct, byte_d;
    logic [15:0] smp_word, word;
    logic fifo_valid;
    logic [15:0] fifo_data;

    function automatic logic [7:0] x5(input logic [4:0] v);
        x5 = {3'h0, v};
    endfunction : x5

    // Checksum over unpacked field values
    assign chk = did_ff + {4'h0, bid_ff} + x5(lid_ff) + {7'h0, scr_ff} + x5(L_M1)
        + F_M1 + x5(fpm_ff[4:0]) + M_M1 + {6'h0, cs_ff} + x5(`SLA_N_M1)
        + x5({2'h0, `SLA_SUBCLASS}) + x5(`SLA_NP_M1) + x5({2'h0, `SLA_VERSION})
        + x5(S_M1) + {7'h0, HD} + x5(`SLA_CF);

    always_comb begin
        nxt_tail = tail_ff;
        nxt_lane = lane_ff;
        nxt_did = did_ff;
        nxt_bid = bid_ff;
        nxt_lid = lid_ff;
        nxt_scr = scr_ff;
        nxt_fpm = fpm_ff;
        nxt_cs = cs_ff;
        if (REG_WR) begin
            case (REG_ADDR)
                `SLA_A_TAIL: nxt_tail = REG_WDATA;
                `SLA_A_LANE: nxt_lane = REG_WDATA;
                `SLA_A_DID: nxt_did = REG_WDATA;
                `SLA_A_BID: nxt_bid = REG_WDATA[3:0];
                `SLA_A_LID: nxt_lid = REG_WDATA[4:0];
                `SLA_A_SCR: nxt_scr = REG_WDATA[`SLA_B_SCR];
                `SLA_A_FPM: nxt_fpm = REG_WDATA;
                `SLA_A_CSR: nxt_cs = REG_WDATA[`SLA_F_CS];
                default: nxt_tail = tail_ff;
            endcase
        end
        case (REG_ADDR)
            `SLA_A_TAIL: nxt_rdata = tail_ff;
            `SLA_A_LANE: nxt_rdata = lane_ff;
            `SLA_A_DID: nxt_rdata = did_ff;
            `SLA_A_BID: nxt_rdata = {4'h0, bid_ff};
            `SLA_A_LID: nxt_rdata = x5(lid_ff);
            `SLA_A_SCR: nxt_rdata = {scr_ff, 2'h0, L_M1};
            `SLA_A_OPF: nxt_rdata = F_M1;
            `SLA_A_FPM: nxt_rdata = fpm_ff;
            `SLA_A_CNV: nxt_rdata = M_M1;
            `SLA_A_CSR: nxt_rdata = {cs_ff, 2'h0, 4'(`SLA_N_M1)};
            `SLA_A_BPS: nxt_rdata = {4'h0, 4'(`SLA_NP_M1)};
            `SLA_A_SPF: nxt_rdata = x5(S_M1);
            `SLA_A_DCW: nxt_rdata = {HD, 2'h0, `SLA_CF};
            `SLA_A_CHK: nxt_rdata = chk;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            tail_ff <= `SLA_R_BYTE;
            lane_ff <= `SLA_R_BYTE;
            did_ff <= `SLA_R_BYTE;
            bid_ff <= 4'h0;
            lid_ff <= 5'h00;
            scr_ff <= `SLA_R_SCR;
            fpm_ff <= `SLA_R_FPM;
            cs_ff <= 2'h0;
            rdata_ff <= `SLA_R_BYTE;
        end else begin
            tail_ff <= nxt_tail;
            lane_ff <= nxt_lane;
            did_ff <= nxt_did;
            bid_ff <= nxt_bid;
            lid_ff <= nxt_lid;
            scr_ff <= nxt_scr;
            fpm_ff <= nxt_fpm;
            cs_ff <= nxt_cs;
            rdata_ff <= nxt_rdata;
        end
    end

    // Sample slot: converter bits, three filler bits, two tail/control bits
    always_comb begin
        prn = lane_ff[`SLA_B_PRN];
        smp_word = {SMP_DATA, prn ? lfsr_ff[2:0] : tail_ff[`SLA_F_FILL], 2'b00};
        case (cs_ff)
            2'h0: smp_word[1:0] = prn ? lfsr_ff[4:3] : 2'b00;
            2'h1: smp_word[1:0] = {SMP_OVR, prn ? lfsr_ff[3] : 1'b0};
            default: smp_word[1:0] = {SMP_OVR, SMP_VALID};
        endcase
    end

    sla_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(MCLK),
        .rst_n(NRST),
        .flush(lane_rst),
        .in_valid(SMP_VALID),
        .in_data(smp_word),
        .in_ready(SMP_READY),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(pop)
    );

    always_comb begin
        case (idx - `SLA_IDX_CFG0)
            8'd0: cfg_oct = did_ff;
            8'd1: cfg_oct = {4'h0, bid_ff};
            8'd2: cfg_oct = x5(lid_ff);
            8'd3: cfg_oct = {scr_ff, 2'h0, L_M1};
            8'd4: cfg_oct = F_M1;
            8'd5: cfg_oct = x5(fpm_ff[4:0]);
            8'd6: cfg_oct = M_M1;
            8'd7: cfg_oct = {cs_ff, 1'b0, `SLA_N_M1};
            8'd8: cfg_oct = {`SLA_SUBCLASS, `SLA_NP_M1};
            8'd9: cfg_oct = {`SLA_VERSION, S_M1};
            8'd10: cfg_oct = {HD, 2'h0, `SLA_CF};
            8'd13: cfg_oct = chk;
            default: cfg_oct = 8'h00;
        endcase
    end

    always_comb begin
        lane_rst = lane_ff[`SLA_B_LANE_RST];
        mode = sla_ilas_t'(lane_ff[`SLA_F_ILAS]);
        at_fe = (oct_ff == F_M1[1:0]);
        at_me = at_fe && (frm_ff == fpm_ff[4:0]);
        idx = DUAL ? {1'b0, frm_ff, oct_ff} : {2'h0, frm_ff, oct_ff[0]};
        pop = (st_ff == ST_DATA) && !oct_ff[0] && !lane_rst && SYNC_N;
        // An underrun sends a zero sample rather than stalling the lane
        word = fifo_valid ? fifo_data : 16'h0000;
        byte_d = oct_ff[0] ? hold_ff : word[15:8];
        nxt_st = st_ff;
        nxt_oct = oct_ff;
        nxt_frm = frm_ff;
        nxt_mf = mf_ff;
        nxt_prev = prev_ff;
        nxt_prev_ok = prev_ok_ff;
        nxt_hold = pop ? word[7:0] : hold_ff;
        nxt_lfsr = {lfsr_ff[13:0], lfsr_ff[14] ^ lfsr_ff[13]};
        nxt_oct_out = 8'h00;
        nxt_ctrl = 1'b0;
        nxt_scro = 1'b0;
        nxt_act = 1'b1;
        if (st_ff == ST_ILAS || st_ff == ST_DATA) begin
            nxt_oct = at_fe ? 2'h0 : oct_ff + 2'h1;
            if (at_fe) begin
                nxt_frm = at_me ? 5'h00 : frm_ff + 5'h01;
            end
        end
        case (st_ff)
            ST_OFF: begin
                nxt_act = 1'b0;
                nxt_st = ST_CGS;
            end
            ST_CGS: begin
                nxt_oct_out = `SLA_K_K;
                nxt_ctrl = 1'b1;
                nxt_mf = 2'h0;
                nxt_prev_ok = 1'b0;
                if (SYNC_N) begin
                    nxt_st = (mode == ILAS_SKIP) ? ST_DATA : ST_ILAS;
                end
            end
            ST_ILAS: begin
                nxt_ctrl = 1'b1;
                if (idx == 8'h00) begin
                    nxt_oct_out = `SLA_K_R;
                end else if (at_me) begin
                    nxt_oct_out = `SLA_K_A;
                end else if (mf_ff == 2'h1 && idx == `SLA_IDX_Q) begin
                    nxt_oct_out = `SLA_K_Q;
                end else if (mf_ff == 2'h1 && idx <= `SLA_IDX_CFGN) begin
                    nxt_oct_out = cfg_oct;
                    nxt_ctrl = 1'b0;
                end else begin
                    // Dummy octets fill out the multiframe
                    nxt_oct_out = idx;
                    nxt_ctrl = 1'b0;
                end
                if (at_me) begin
                    nxt_mf = mf_ff + 2'h1;
                    if (mf_ff == `SLA_MF_LAST && mode != ILAS_REPEAT) begin
                        nxt_st = ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                nxt_oct_out = byte_d;
                nxt_scro = scr_ff;
                if (at_fe) begin
                    nxt_prev = byte_d;
                    nxt_prev_ok = 1'b1;
                    if (scr_ff) begin
                        if (at_me && byte_d == `SLA_K_A) begin
                            nxt_ctrl = 1'b1;
                        end else if (!at_me && byte_d == `SLA_K_F) begin
                            nxt_ctrl = 1'b1;
                        end
                    end else if (prev_ok_ff && byte_d == prev_ff) begin
                        nxt_ctrl = 1'b1;
                        nxt_oct_out = at_me ? `SLA_K_A : `SLA_K_F;
                    end
                end
            end
            default: nxt_st = ST_OFF;
        endcase
        // Sync request mid-link forces a fresh synchronisation
        if (st_ff != ST_OFF && !SYNC_N) begin
            nxt_st = ST_CGS;
            nxt_oct = 2'h0;
            nxt_frm = 5'h00;
        end
        if (lane_rst) begin
            nxt_st = ST_OFF;
            nxt_oct = 2'h0;
            nxt_frm = 5'h00;
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            st_ff <= ST_OFF;
            oct_ff <= 2'h0;
            frm_ff <= 5'h00;
            mf_ff <= 2'h0;
            prev_ff <= 8'h00;
            prev_ok_ff <= 1'b0;
            hold_ff <= 8'h00;
            lfsr_ff <= `SLA_PRN_SEED;
            oct_out_ff <= 8'h00;
            ctrl_ff <= 1'b0;
            scro_ff <= 1'b0;
            act_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            oct_ff <= nxt_oct;
            frm_ff <= nxt_frm;
            mf_ff <= nxt_mf;
            prev_ff <= nxt_prev;
            prev_ok_ff <= nxt_prev_ok;
            hold_ff <= nxt_hold;
            lfsr_ff <= nxt_lfsr;
            oct_out_ff <= nxt_oct_out;
            ctrl_ff <= nxt_ctrl;
            scro_ff <= nxt_scro;
            act_ff <= nxt_act;
        end
    end

    assign REG_RDATA = rdata_ff;
    assign LANE_OCTET = oct_out_ff;
    assign LANE_CTRL = ctrl_ff;
    assign LANE_SCRAMBLE = scro_ff;
    assign LANE_ACTIVE = act_ff;

    ilas_start_a: assert property (@(posedge MCLK) disable iff (!NRST)
        st_ff == ST_CGS && SYNC_N && !lane_rst && mode == ILAS_ONCE |=> st_ff == ST_ILAS)
        else $error("Alignment did not start after sync release");
    cgs_char_a: assert property (@(posedge MCLK) disable iff (!NRST)
        st_ff == ST_CGS |=> LANE_OCTET == `SLA_K_K && LANE_CTRL)
        else $error("Sync character missing");
    mf_open_a: assert property (@(posedge MCLK) disable iff (!NRST)
        st_ff == ST_ILAS && idx == 8'h00 && SYNC_N && !lane_rst
        |=> LANE_OCTET == `SLA_K_R && LANE_CTRL)
        else $error("Multiframe start character wrong");
    mf_close_a: assert property (@(posedge MCLK) disable iff (!NRST)
        st_ff == ST_ILAS && at_me && SYNC_N && !lane_rst
        |=> LANE_OCTET == `SLA_K_A && LANE_CTRL)
        else $error("Multiframe end character wrong");
    cfg_marker_a: assert property (@(posedge MCLK) disable iff (!NRST)
        st_ff == ST_ILAS && mf_ff == 2'h1 && idx == `SLA_IDX_Q && SYNC_N && !lane_rst
        |=> LANE_OCTET == `SLA_K_Q ##1 !LANE_CTRL && LANE_OCTET == did_ff)
        else $error("Configuration marker or first octet wrong");
    chk_octet_a: assert property (@(posedge MCLK) disable iff (!NRST)
        st_ff == ST_ILAS && mf_ff == 2'h1 && idx == `SLA_IDX_CFGN && SYNC_N && !lane_rst
        |=> LANE_OCTET == $past(chk) && !LANE_CTRL)
        else $error("Checksum octet wrong");
    lane_off_a: assert property (@(posedge MCLK) disable iff (!NRST)
        REG_WR && REG_ADDR == `SLA_A_LANE && REG_WDATA[`SLA_B_LANE_RST]
        |=> ##1 st_ff == ST_OFF ##1 !LANE_ACTIVE)
        else $error("Lane did not enter reset");
    data_follow_a: assert property (@(posedge MCLK) disable iff (!NRST)
        st_ff == ST_ILAS && at_me && mf_ff == `SLA_MF_LAST && mode == ILAS_ONCE
        && SYNC_N && !lane_rst |=> st_ff == ST_DATA && oct_ff == 2'h0 && frm_ff == 5'h00)
        else $error("Data did not follow alignment");
    scr_phase_a: assert property (@(posedge MCLK) disable iff (!NRST)
        LANE_SCRAMBLE |-> $past(st_ff) == ST_DATA)
        else $error("Scrambling outside data phase");
    frame_wrap_a: assert property (@(posedge MCLK) disable iff (!NRST)
        st_ff == ST_DATA && at_me && SYNC_N && !lane_rst |=> frm_ff == 5'h00)
        else $error("Multiframe length wrong");
endmodule : sla_link_tx

// ### hw/sla_defines.svh
`ifndef SLA_DEFINES_SVH
`define SLA_DEFINES_SVH
`define SLA_A_TAIL 8'h14
`define SLA_A_LANE 8'h5f
`define SLA_A_DID 8'h64
`define SLA_A_BID 8'h65
`define SLA_A_LID 8'h67
`define SLA_A_SCR 8'h6e
`define SLA_A_OPF 8'h6f
`define SLA_A_FPM 8'h70
`define SLA_A_CNV 8'h71
`define SLA_A_CSR 8'h72
`define SLA_A_BPS 8'h73
`define SLA_A_SPF 8'h74
`define SLA_A_DCW 8'h75
`define SLA_A_CHK 8'h79
`define SLA_R_BYTE 8'h00
`define SLA_R_FPM 8'h1f
`define SLA_R_SCR 1'b1
`define SLA_B_LANE_RST 0
`define SLA_B_PRN 6
`define SLA_B_SCR 7
`define SLA_F_ILAS 3:2
`define SLA_F_CS 7:6
`define SLA_F_FILL 7:5
`define SLA_K_R 8'h1c
`define SLA_K_A 8'h7c
`define SLA_K_Q 8'h9c
`define SLA_K_K 8'hbc
`define SLA_K_F 8'hfc
`define SLA_QC_DEFAULT 8'h11
`define SLA_QC_DUAL 8'h21
`define SLA_N_M1 5'h0a
`define SLA_NP_M1 5'h0f
`define SLA_CF 5'h00
`define SLA_SUBCLASS 3'h1
`define SLA_VERSION 3'h1
`define SLA_MF_LAST 2'h3
`define SLA_IDX_Q 8'h01
`define SLA_IDX_CFG0 8'h02
`define SLA_IDX_CFGN 8'h0f
`define SLA_PRN_SEED 15'h7fff
`endif

// ### hw/sla_pkg.sv
package sla_pkg;
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_CGS = 2'b01,
        ST_ILAS = 2'b10,
        ST_DATA = 2'b11
    } sla_state_t;
    typedef enum logic [1:0] {
        ILAS_ONCE = 2'b00,
        ILAS_SKIP = 2'b01,
        ILAS_REPEAT = 2'b10,
        ILAS_ONCE_ALT = 2'b11
    } sla_ilas_t;
endpackage : sla_pkg

// ### verification/sla_rx_model.sv
`timescale 1ns/1ps
module sla_rx_model #(
    parameter int CGS_LEN = 48
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] lane_octet,
    input wire logic lane_ctrl,
    input wire logic lane_active,
    output logic sync_n
);
    int unsigned seen;
    // Any lane reset drops the link back into resync
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen <= 0;
            sync_n <= 1'b0;
        end else if (!lane_active) begin
            seen <= 0;
            sync_n <= 1'b0;
        end else if (lane_ctrl && lane_octet == 8'hbc && seen < CGS_LEN) begin
            seen <= seen + 1;
        end else if (seen == CGS_LEN) begin
            sync_n <= 1'b1;
        end
    end
endmodule : sla_rx_model

// ### verification/sla_link_tx_bench.sv
`timescale 1ns/1ps
module sla_link_tx_bench;
    localparam int KF = 24;
    localparam logic [15:0] RST_TAB [12] = '{16'h5f00, 16'h6e80, 16'h6f01, 16'h701f,
        16'h7100, 16'h720a, 16'h730f, 16'h7400, 16'h7500, 16'h793c, 16'h1400, 16'h3000};
    localparam logic [7:0] MODE [3] = '{8'h00, 8'h0c, 8'h04};
    logic MCLK = 1'b0;
    logic NRST = 1'b0;
    logic REG_WR = 1'b0;
    logic [7:0] REG_ADDR = 8'h00;
    logic [7:0] REG_WDATA = 8'h00;
    logic [7:0] REG_RDATA;
    logic SYNC_N;
    logic [10:0] SMP_DATA = 11'h000;
    logic SMP_OVR = 1'b0;
    logic SMP_VALID = 1'b0;
    logic SMP_READY;
    logic [7:0] LANE_OCTET;
    logic LANE_CTRL;
    logic LANE_SCRAMBLE;
    logic LANE_ACTIVE;
    int miscompares = 0;
    int total_checks = 0;
    logic [31:0] seed = 32'd18;
    logic [15:0] words[$];
    logic [7:0] cfg[14];

    always #2 MCLK = ~MCLK;

    sla_link_tx dut_u (.MCLK(MCLK), .NRST(NRST), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .SYNC_N(SYNC_N), .SMP_DATA(SMP_DATA),
        .SMP_OVR(SMP_OVR), .SMP_VALID(SMP_VALID), .SMP_READY(SMP_READY),
        .LANE_OCTET(LANE_OCTET), .LANE_CTRL(LANE_CTRL), .LANE_SCRAMBLE(LANE_SCRAMBLE),
        .LANE_ACTIVE(LANE_ACTIVE));
    sla_rx_model rx_u (.clk(MCLK), .rst_n(NRST), .lane_octet(LANE_OCTET),
        .lane_ctrl(LANE_CTRL), .lane_active(LANE_ACTIVE), .sync_n(SYNC_N));

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs

    // Symbol is {scramble, k flag, octet}
    function automatic logic [9:0] ilas_exp(input int i);
        int j;
        j = i % KF;
        if (j == 0) return 10'h11c;
        if (j == KF - 1) return 10'h17c;
        if (i / KF == 1 && j == 1) return 10'h19c;
        if (i / KF == 1 && j < 16) return {2'b00, cfg[j-2]};
        return {2'b00, 8'(j)};
    endfunction : ilas_exp

    // Replacement compares raw octets, the scrambler sits downstream
    function automatic logic [9:0] data_exp(input int f, input int o, input logic sc);
        logic [7:0] raw;
        logic [7:0] prv;
        logic mfe;
        raw = o ? words[f][7:0] : words[f][15:8];
        if (o == 0) return {sc, 1'b0, raw};
        prv = f ? words[f-1][7:0] : 8'h00;
        mfe = (f % 12) == 11;
        if (!sc && f > 0 && raw == prv) return {2'b01, mfe ? 8'h7c : 8'hfc};
        if (sc && raw == (mfe ? 8'h7c : 8'hfc)) return {2'b11, raw};
        return {sc, 1'b0, raw};
    endfunction : data_exp

    task automatic close_out;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk_lane(input logic [9:0] exp);
        total_checks++;
        if ({LANE_SCRAMBLE, LANE_CTRL, LANE_OCTET} !== exp) begin
            miscompares++;
            $display("[ERR] %0t lane %h%h%h expected %h", $time, LANE_SCRAMBLE, LANE_CTRL,
                LANE_OCTET, exp);
        end
    endtask : chk_lane

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge MCLK);
        REG_WR <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge MCLK);
        REG_ADDR <= a;
        repeat (2) @(posedge MCLK);
        #1 d = REG_RDATA;
    endtask : rd

    initial begin
        logic [7:0] v;
        logic [7:0] chk;
        logic [7:0] id[3];
        logic sc;
        int n;
        int il;
        logic [1:0] cs;
        repeat (10) @(posedge MCLK);
        NRST <= 1'b1;
        foreach (RST_TAB[i]) begin
            rd(RST_TAB[i][15:8], v);
            chk8(v, RST_TAB[i][7:0]);
        end
        wr(8'h6f, 8'hff);
        rd(8'h6f, v);
        chk8(v, 8'h01);
        for (int p = 0; p < 3; p++) begin
            sc = (p == 1);
            // Overrange and valid ride in the tail on the last pass only
            cs = (p == 2) ? 2'h2 : 2'h0;
            wr(8'h5f, 8'h01);
            repeat (3) @(posedge MCLK);
            #1 chk8({6'h00, LANE_ACTIVE, SMP_READY}, 8'h00);
            seed = xs(seed);
            id = '{seed[7:0], {4'h0, seed[11:8]}, {3'h0, seed[20:16]}};
            wr(8'h64, id[0]);
            wr(8'h65, id[1]);
            wr(8'h67, id[2]);
            wr(8'h70, 8'h0b);
            wr(8'h6e, {sc, 7'h00});
            wr(8'h14, sc ? 8'he0 : 8'h00);
            wr(8'h72, {cs, 6'h00});
            chk = id[0] + id[1] + id[2] + {7'h00, sc} + {6'h00, cs} + 8'd39;
            cfg = '{id[0], id[1], id[2], {sc, 7'h00}, 8'h01, 8'h0b, 8'h00, {cs, 6'h0a}, 8'h2f,
                8'h20, 8'h00, 8'h00, 8'h00, chk};
            rd(8'h79, v);
            chk8(v, chk);
            rd(8'h72, v);
            chk8(v, {cs, 6'h0a});
            wr(8'h5f, MODE[p]);
            words.delete();
            n = 0;
            do begin
                @(posedge MCLK);
                if (SMP_VALID && SMP_READY)
                    words.push_back({SMP_DATA, sc ? 3'h7 : 3'h0,
                        cs[1] ? {SMP_OVR, 1'b1} : 2'b00});
                seed = xs(seed);
                SMP_DATA <= {seed[10:3], sc ? {seed[0], 2'b11} : {2'b00, seed[0]}};
                SMP_OVR <= seed[1];
                SMP_VALID <= 1'b1;
                n++;
            end while ((words.size() == 0 || SMP_READY) && n < 80);
            // Let the last valid edge pass before dropping valid
            @(posedge MCLK);
            SMP_VALID <= 1'b0;
            chk8(8'(words.size()), 8'd32);
            n = 0;
            do begin
                @(posedge MCLK);
                #1 n++;
                if (LANE_ACTIVE && !(LANE_CTRL && LANE_OCTET == 8'hbc)) break;
                if (LANE_ACTIVE) chk_lane(10'h1bc);
            end while (n < 300);
            if (n >= 300) begin
                miscompares++;
                $display("[ERR] %0t no alignment start", $time);
                close_out();
            end
            il = (p == 2) ? 0 : 4 * KF;
            for (int s = 0; s < il + 2 * words.size(); s++) begin
                if (s > 0) begin
                    @(posedge MCLK);
                    #1;
                end
                if (s < il)
                    chk_lane(ilas_exp(s));
                else
                    chk_lane(data_exp((s - il) / 2, s % 2, sc));
            end
        end
        close_out();
    end
endmodule : sla_link_tx_bench
